// ---- verilog/inverter_drive_pkg.sv ----
package inverter_drive_pkg;
    // system clock rate
    localparam int unsigned CLOCK_HZ          = 100_000_000;
    // switching frequency limits
    localparam int unsigned FREQ_MIN_HZ       = 110_000;
    localparam int unsigned FREQ_MAX_HZ       = 148_000;
    // period limits in clock cycles; longest period rounds down, shortest rounds up
    localparam int unsigned PERIOD_MAX_CYC    = CLOCK_HZ / FREQ_MIN_HZ;
    localparam int unsigned PERIOD_MIN_CYC    = (CLOCK_HZ + FREQ_MAX_HZ - 1) / FREQ_MAX_HZ;
    localparam int unsigned PERIOD_W          = 12;
    // default operating point
    localparam logic [11:0] PERIOD_RESET      = 12'h2ee;
    localparam logic [11:0] DUTY_RESET        = 12'h177;
    // correction step sizes, in cycles
    localparam logic [11:0] STEP_CYC          = 12'h004;
    // non-overlap interval
    localparam int unsigned DEAD_NS           = 50;
    localparam int unsigned DEAD_CYC          = (DEAD_NS * (CLOCK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned DEAD_W            = 4;
    // signed error value width
    localparam int unsigned ERR_W             = 8;
endpackage

// ---- verilog/inverter_link_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface inverter_link_if;
    logic phase_command_out_alt;
    logic leg_a_drive_in;
    logic leg_b_drive_in;
    logic half_bridge_select;

    modport device (
        output phase_command_out_alt,
        input  leg_a_drive_in,
        input  leg_b_drive_in
    );
    modport glue (
        input  phase_command_out_alt,
        output half_bridge_select,
        output leg_a_drive_in,
        output leg_b_drive_in
    );
endinterface
`default_nettype wire

// ---- verilog/edge_decode_glue.sv ----
`timescale 1ns/1ps
`default_nettype none
module edge_decode_glue
    import inverter_drive_pkg::*;
(
    input  wire logic     i_clock,
    input  wire logic     i_rst_n,
    input  wire logic     i_half_bridge_select,
    inverter_link_if.glue link
);
    logic cmd_s1_r;
    logic cmd_s2_r;
    logic cmd_s3_r;
    logic hb_s1_r;
    logic hb_s2_r;
    logic leg_a_r;
    logic leg_b_r;
    logic leg_a_nxt;
    logic leg_b_nxt;
    logic rise;
    logic fall;

    assign link.half_bridge_select = i_half_bridge_select;
    assign link.leg_a_drive_in     = leg_a_r;
    assign link.leg_b_drive_in     = leg_b_r;

    assign rise = cmd_s2_r & ~cmd_s3_r;
    assign fall = ~cmd_s2_r & cmd_s3_r;

    always_comb begin
        leg_a_nxt = leg_a_r;
        leg_b_nxt = leg_b_r;
        if (hb_s2_r) begin
            leg_a_nxt = cmd_s2_r; // [RQ6] [RQ7]
            leg_b_nxt = 1'b0;
        end else begin
            // rising edge toggles leg a, falling toggles leg b: command duty sets phase
            if (rise) begin
                leg_a_nxt = ~leg_a_r; // [RQ3] [RQ5]
            end
            if (fall) begin
                leg_b_nxt = ~leg_b_r; // [RQ3] [RQ5]
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            cmd_s1_r <= 1'b0;
            cmd_s2_r <= 1'b0;
            cmd_s3_r <= 1'b0;
            hb_s1_r  <= 1'b0;
            hb_s2_r  <= 1'b0;
            leg_a_r  <= 1'b0;
            leg_b_r  <= 1'b0;
        end else begin
            cmd_s1_r <= link.phase_command_out_alt;
            cmd_s2_r <= cmd_s1_r;
            cmd_s3_r <= cmd_s2_r;
            hb_s1_r  <= i_half_bridge_select;
            hb_s2_r  <= hb_s1_r;
            leg_a_r  <= leg_a_nxt;
            leg_b_r  <= leg_b_nxt;
        end
    end
endmodule
`default_nettype wire

// ---- verilog/inverter_phase_shift_drive.sv ----
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// RQ1: switching frequency held within 110 to 148 kHz (full-bridge legs toggle once per command period, so 55 to 74 kHz)
// RQ2: each control error packet adjusts frequency or duty
// RQ3: glue decodes both command edges into leg drives
// RQ4: four gates full-bridge, leg a only half-bridge
// RQ5: command duty sets phase between leg highs
// RQ6: glue takes active-high half-bridge select
// RQ7: half-bridge leg a drive follows command output
// RQ8: low gate complements high gate per leg
// RQ9: non-overlap gap between high and low gates
module inverter_phase_shift_drive
    import inverter_drive_pkg::*;
#(
    parameter int unsigned DEAD_CYCLES = DEAD_CYC
) (
    input  wire logic              i_clock,
    input  wire logic              i_rst_n,
    input  wire logic              i_transfer_active,
    input  wire logic              i_half_bridge_select,
    input  wire logic              i_control_error_packet_valid,
    input  wire logic [ERR_W-1:0]  i_control_error_packet,
    input  wire logic              i_adjust_duty,
    output logic                   o_leg_a_high_gate,
    output logic                   o_leg_a_low_gate,
    output logic                   o_leg_b_high_gate,
    output logic                   o_leg_b_low_gate,
    output logic [PERIOD_W-1:0]    o_period,
    output logic [PERIOD_W-1:0]    o_duty,
    inverter_link_if.device        link
);
    localparam logic [PERIOD_W-1:0] P_MAX = PERIOD_W'(PERIOD_MAX_CYC);
    localparam logic [PERIOD_W-1:0] P_MIN = PERIOD_W'(PERIOD_MIN_CYC);
    localparam logic [DEAD_W-1:0]   DEAD  = DEAD_W'(DEAD_CYCLES);

    logic [PERIOD_W-1:0] period_r;
    logic [PERIOD_W-1:0] period_nxt;
    logic [PERIOD_W-1:0] duty_r;
    logic [PERIOD_W-1:0] duty_nxt;
    logic [PERIOD_W-1:0] cnt_r;
    logic [PERIOD_W-1:0] cnt_nxt;
    logic                cmd_r;
    logic                cmd_nxt;
    logic                a_s1_r;
    logic                a_s2_r;
    logic                b_s1_r;
    logic                b_s2_r;
    logic                hb_s1_r;
    logic                hb_s2_r;
    logic [1:0]          hi_g;
    logic [1:0]          lo_g;
    logic                err_neg;
    logic                err_zero;

    assign link.phase_command_out_alt = cmd_r;
    assign o_period = period_r;
    assign o_duty   = duty_r;
    assign err_neg  = i_control_error_packet[ERR_W-1];
    assign err_zero = (i_control_error_packet == '0);

    always_comb begin
        period_nxt = period_r;
        duty_nxt   = duty_r;
        if (i_transfer_active && i_control_error_packet_valid && !err_zero) begin
            if (i_adjust_duty) begin
                // positive error asks for more power: wider command duty
                if (!err_neg && duty_r + STEP_CYC < period_r) begin
                    duty_nxt = duty_r + STEP_CYC; // [RQ2] [RQ5]
                end else if (err_neg && duty_r > STEP_CYC) begin
                    duty_nxt = duty_r - STEP_CYC; // [RQ2]
                end
            end else begin
                // more power means lower frequency, nearer resonance
                if (!err_neg && period_r + STEP_CYC <= P_MAX) begin
                    period_nxt = period_r + STEP_CYC; // [RQ2] [RQ1]
                end else if (err_neg && period_r >= P_MIN + STEP_CYC) begin
                    period_nxt = period_r - STEP_CYC; // [RQ2] [RQ1]
                    // keep duty under the shorter period so the command still falls
                    if (duty_r >= period_r - STEP_CYC) begin
                        duty_nxt = period_r - STEP_CYC - 12'h001;
                    end
                end
            end
        end
    end

    always_comb begin
        cnt_nxt = (cnt_r + 12'h001 >= period_r) ? '0 : cnt_r + 12'h001; // [RQ1]
        cmd_nxt = (cnt_nxt < duty_r);
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            period_r <= PERIOD_RESET;
            duty_r   <= DUTY_RESET;
            cnt_r    <= '0;
            cmd_r    <= 1'b0;
        end else begin
            period_r <= period_nxt;
            duty_r   <= duty_nxt;
            cnt_r    <= cnt_nxt;
            cmd_r    <= cmd_nxt;
        end
    end

    // leg drives arrive as pins; both legs pay the same two-cycle delay, so phase is kept
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            a_s1_r   <= 1'b0;
            a_s2_r   <= 1'b0;
            b_s1_r   <= 1'b0;
            b_s2_r   <= 1'b0;
            hb_s1_r  <= 1'b0;
            hb_s2_r  <= 1'b0;
        end else begin
            a_s1_r   <= link.leg_a_drive_in;
            a_s2_r   <= a_s1_r;
            b_s1_r   <= link.leg_b_drive_in;
            b_s2_r   <= b_s1_r;
            hb_s1_r  <= i_half_bridge_select;
            hb_s2_r  <= hb_s1_r;
        end
    end

    // leg b stays off in half-bridge mode; its gates both low
    deadtime_leg #(.DEAD(DEAD)) u_leg_a (
        .i_clock  (i_clock),
        .i_rst_n  (i_rst_n),
        .i_enable (1'b1),
        .i_drive  (a_s2_r),
        .o_high   (hi_g[0]),
        .o_low    (lo_g[0])
    );
    deadtime_leg #(.DEAD(DEAD)) u_leg_b (
        .i_clock  (i_clock),
        .i_rst_n  (i_rst_n),
        .i_enable (~hb_s2_r),       // [RQ4]
        .i_drive  (b_s2_r),
        .o_high   (hi_g[1]),
        .o_low    (lo_g[1])
    );

    assign o_leg_a_high_gate = hi_g[0]; // [RQ4]
    assign o_leg_a_low_gate  = lo_g[0];
    assign o_leg_b_high_gate = hi_g[1];
    assign o_leg_b_low_gate  = lo_g[1];
endmodule

module deadtime_leg
    import inverter_drive_pkg::*;
#(
    parameter logic [DEAD_W-1:0] DEAD = 4'h5
) (
    input  wire logic i_clock,
    input  wire logic i_rst_n,
    input  wire logic i_enable,
    input  wire logic i_drive,
    output logic      o_high,
    output logic      o_low
);
    logic              state_r;
    logic              state_nxt;
    logic [DEAD_W-1:0] gap_r;
    logic [DEAD_W-1:0] gap_nxt;
    logic              high_r;
    logic              high_nxt;
    logic              low_r;
    logic              low_nxt;
    logic              target;

    assign target = i_enable & i_drive;
    assign o_high = high_r;
    assign o_low  = low_r;

    always_comb begin
        state_nxt = state_r;
        gap_nxt   = gap_r;
        high_nxt  = 1'b0;
        low_nxt   = 1'b0;
        if (target != state_r) begin
            // both gates off for the gap before the new side turns on
            state_nxt = target;
            gap_nxt   = DEAD; // [RQ9]
        end else if (gap_r != '0) begin
            gap_nxt = gap_r - 4'h1;
        end else if (i_enable) begin
            high_nxt = state_r;
            low_nxt  = ~state_r; // [RQ8]
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            state_r <= 1'b0;
            // gap runs from reset, so no gate turns on in the first cycles
            gap_r   <= DEAD;
            high_r  <= 1'b0;
            low_r   <= 1'b0;
        end else begin
            state_r <= state_nxt;
            gap_r   <= gap_nxt;
            high_r  <= high_nxt;
            low_r   <= low_nxt;
        end
    end
endmodule
`default_nettype wire

// ---- test/inverter_link_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module inverter_link_checker
    import inverter_drive_pkg::*;
(
    input  wire logic i_clock,
    input  wire logic i_rst_n,
    input  wire logic i_phase_command_out_alt,
    input  wire logic i_leg_a_drive_in,
    input  wire logic i_leg_b_drive_in,
    input  wire logic i_half_bridge_select
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    logic [11:0] since_rise_r;
    logic [11:0] since_rise_nxt;
    logic        cmd_d_r;
    // mode must settle through the glue synchronisers first
    sequence full_mode; !i_half_bridge_select [*6]; endsequence
    sequence half_mode; i_half_bridge_select [*6]; endsequence
    always_comb begin
        since_rise_nxt = since_rise_r + 12'h001;
        if (i_phase_command_out_alt && !cmd_d_r) begin
            since_rise_nxt = 12'h000;
        end
    end
    always_ff @(posedge i_clock) begin
        since_rise_r <= i_rst_n ? since_rise_nxt : 12'h000;
        cmd_d_r      <= i_rst_n ? i_phase_command_out_alt : 1'b0;
    end
    a_on_rise_a: assert property (full_mode ##0 $rose(i_phase_command_out_alt)
        |-> ##[1:4] $changed(i_leg_a_drive_in)) else $error("leg a missed rise");
    b_on_fall_a: assert property (full_mode ##0 $fell(i_phase_command_out_alt)
        |-> ##[1:4] $changed(i_leg_b_drive_in)) else $error("leg b missed fall");
    a_holds_a: assert property (
        (!i_half_bridge_select && $stable(i_phase_command_out_alt)) [*8]
        |-> $stable(i_leg_a_drive_in)) else $error("leg a moved alone");
    b_holds_a: assert property (
        (!i_half_bridge_select && $stable(i_phase_command_out_alt)) [*8]
        |-> $stable(i_leg_b_drive_in)) else $error("leg b moved alone");
    half_b_low_a: assert property (half_mode |-> !i_leg_b_drive_in)
        else $error("leg b active in half bridge");
    half_rise_a: assert property (half_mode ##0 $rose(i_phase_command_out_alt)
        |-> ##[1:4] i_leg_a_drive_in) else $error("leg a not following rise");
    half_fall_a: assert property (half_mode ##0 $fell(i_phase_command_out_alt)
        |-> ##[1:4] !i_leg_a_drive_in) else $error("leg a not following fall");
    period_bound_a: assert property (since_rise_r < PERIOD_MAX_CYC)
        else $error("command period too long");
endmodule
`default_nettype wire

// ---- test/test_inverter_phase_shift_drive.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_inverter_phase_shift_drive;
    import inverter_drive_pkg::*;
    logic        i_clock, i_rst_n, transfer_active, half_sel, pkt_valid, adjust_duty;
    logic        a_hi, a_lo, b_hi, b_lo;
    logic [7:0]  pkt_err;
    logic [11:0] period, duty;
    logic [31:0] seed = 32'h0000_0029;
    logic [31:0] rnd;
    int          bad_count, compares, exp_p, exp_d, n;
    inverter_link_if link_if ();
    inverter_phase_shift_drive inverter_phase_shift_drive_inst (.i_clock(i_clock),
        .i_rst_n(i_rst_n), .i_transfer_active(transfer_active), .i_half_bridge_select(half_sel),
        .i_control_error_packet_valid(pkt_valid), .i_control_error_packet(pkt_err),
        .i_adjust_duty(adjust_duty), .o_leg_a_high_gate(a_hi), .o_leg_a_low_gate(a_lo),
        .o_leg_b_high_gate(b_hi), .o_leg_b_low_gate(b_lo), .o_period(period), .o_duty(duty),
        .link(link_if));
    edge_decode_glue edge_decode_glue_inst (.i_clock(i_clock), .i_rst_n(i_rst_n),
        .i_half_bridge_select(half_sel), .link(link_if));
    inverter_link_checker inverter_link_checker_inst (.i_clock(i_clock), .i_rst_n(i_rst_n),
        .i_phase_command_out_alt(link_if.phase_command_out_alt),
        .i_leg_a_drive_in(link_if.leg_a_drive_in),
        .i_leg_b_drive_in(link_if.leg_b_drive_in),
        .i_half_bridge_select(link_if.half_bridge_select));
    initial begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic pick(input int s);
        return (s == 0) ? link_if.phase_command_out_alt : ((s == 1) ? a_hi : b_hi);
    endfunction
    task automatic tally_and_finish();
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic expect_ok(input logic ok, input string what);
        compares++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("[ERR] %0t %s", $time, what);
        end
    endtask
    // counts falling edges until the picked signal is seen to rise
    task automatic wait_rise(input int s, output int cnt);
        logic last;
        last = pick(s);
        cnt = 0;
        while (!(pick(s) === 1'b1 && last === 1'b0)) begin
            last = pick(s);
            @(negedge i_clock);
            cnt++;
            if (cnt > 4000) begin
                expect_ok(1'b0, "no edge seen");
                tally_and_finish();
            end
        end
    endtask
    task automatic send(input logic [7:0] e, input logic d, input logic act);
        int s;
        int np;
        int nd;
        @(negedge i_clock);
        transfer_active = act;
        adjust_duty = d;
        pkt_err = e;
        pkt_valid = 1'b1;
        @(negedge i_clock);
        pkt_valid = 1'b0;
        s = (act && e != 8'h00) ? (e[7] ? -int'(STEP_CYC) : int'(STEP_CYC)) : 0;
        np = d ? exp_p : exp_p + s;
        nd = d ? exp_d + s : exp_d;
        // a shrinking period drags the duty down below it
        if (!d && s < 0 && nd >= np) begin
            nd = np - 1;
        end
        if (np >= PERIOD_MIN_CYC && np <= PERIOD_MAX_CYC && nd >= 1 && nd < np) begin
            exp_p = np;
            exp_d = nd;
        end
        @(negedge i_clock);
        expect_ok(period === 12'(exp_p) && duty === 12'(exp_d), "operating point");
    endtask
    always @(negedge i_clock) begin
        if (i_rst_n) begin
            expect_ok(!(a_hi && a_lo) && !(b_hi && b_lo), "gate overlap");
        end
    end
    initial begin
        i_rst_n = 1'b0;
        transfer_active = 1'b0;
        half_sel = 1'b0;
        pkt_valid = 1'b0;
        pkt_err = 8'h00;
        adjust_duty = 1'b0;
        exp_p = int'(PERIOD_RESET);
        exp_d = int'(DUTY_RESET);
        repeat (4) @(negedge i_clock);
        expect_ok(period === PERIOD_RESET && duty === DUTY_RESET && !(a_hi | b_hi), "reset");
        i_rst_n = 1'b1;
        // walk into both period limits and the duty floor, then wander at random
        for (int i = 0; i < 400; i++) begin
            if (i < 60) send(8'h80, 1'b0, 1'b1);
            else if (i < 130) send(8'h7f, 1'b0, 1'b1);
            else if (i < 250) send(8'hff, 1'b1, 1'b1);
            else if (i == 250) send(8'h00, 1'b0, 1'b1);
            else begin
                rnd = xs();
                send(rnd[7:0], rnd[8], rnd[9]);
            end
        end
        wait_rise(0, n);
        wait_rise(0, n);
        expect_ok(n == exp_p, "command period");
        wait_rise(1, n);
        wait_rise(2, n);
        expect_ok(n == exp_d, "leg phase");
        expect_ok(a_lo === ~a_hi && b_lo === ~b_hi, "low not complement");
        half_sel = 1'b1;
        wait_rise(1, n);
        for (int i = 0; i < 2000; i++) begin
            @(negedge i_clock);
            expect_ok(b_hi === 1'b0 && b_lo === 1'b0, "leg b gates in half bridge");
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
